// ==== design/odc_pkg.sv ====
// constants, types and pin bundle for the odd ratio clock divider
package odc_pkg;

    // ==========================================================
    // counter values
    localparam logic [2:0] CNT_RESET = 3'h0;
    localparam logic [2:0] LAST_DIV3 = 3'h2;
    localparam logic [2:0] LAST_DIV5 = 3'h4;
    // whole input cycles the rising-edge half stays high
    localparam logic [2:0] HIGH_DIV3 = 3'h1;
    localparam logic [2:0] HIGH_DIV5 = 3'h2;
    // count at whose falling edge the half-cycle extension starts
    localparam logic [2:0] NEG_DIV3 = 3'h0;
    localparam logic [2:0] NEG_DIV5 = 3'h1;

    // ==========================================================
    // pin bundle
    typedef struct packed {
        logic enable;
        logic ratio5;
        logic loss;
    } odc_pins_type;

    // enable reads high while nothing drives it
    localparam odc_pins_type PINS_RESET = '{enable: 1'h1, ratio5: 1'h0, loss: 1'h0};
    localparam logic [0:0] FLAG_RESET = 1'h0;

    // ==========================================================
    // gating states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_ARM,
        ST_RUN
    } odc_state_type;

endpackage : odc_pkg

// ==== design/odc_sync.sv ====
// two-flop synchroniser for the pin bundle
`timescale 1ns/1ps
module odc_sync
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // ==========================================================
    // first stage feeds only the second
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage1_q <= RESET_VALUE;
            stage2_q <= RESET_VALUE;
        end
        else
        begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule : odc_sync

// ==== design/odc_divider.sv ====
// divide by three or five with both clock edges and glitch-free gating
//
// Behaviour
// R1 - enable pin sampled on input clock edges only
// R2 - enable reads high when nothing drives it
// R3 - start after one rising then one falling input edge
// R4 - stop after rising edge sampling low and output falling edge
// R5 - pulse in progress always finishes at full width
// R6 - rising and falling input edges both shape the output
// R7 - divide by three: output falls at second cycle's falling edge
// R8 - divide by five: output falls at third cycle's falling edge
// R9 - loss of input or loss guard freezes output steady
// R10 - disabled: true output low, complement high, count restarts full period
// R11 - ratio select is static, changed only while disabled or reset
`timescale 1ns/1ps
module odc_divider
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic ratio5_in,
    input wire logic loss_guard_in,
    output logic div_out,
    output logic div_n_out,
    output logic running_out
);
    import odc_pkg::*;

    odc_pins_type pins_raw;
    odc_pins_type pins_s;
    odc_state_type state_q;
    odc_state_type state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic pos_q;
    logic pos_d;
    logic neg_q;
    logic neg_d;
    logic go_q;
    logic go_d;
    logic ratio_q;
    logic ratio_d;
    logic halt_q;
    logic halt_d;
    logic running_q;
    logic running_d;
    logic [2:0] last_cnt;
    logic [2:0] high_cnt;
    logic [2:0] neg_cnt;

    // ==========================================================
    // pin capture
    assign pins_raw = '{enable: enable_in, ratio5: ratio5_in, loss: loss_guard_in};

    // R1 synchronous enable sampling
    // R2 enable defaults high out of reset
    odc_sync #(
        .WIDTH($bits(odc_pins_type)),
        .RESET_VALUE(PINS_RESET)
    ) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // ==========================================================
    // ratio decode
    // R11 ratio latched while off
    // latched copy keeps a late select change from bending a running period
    always_comb
    begin
        if (ratio_q)
        begin
            last_cnt = LAST_DIV5;
            high_cnt = HIGH_DIV5;
            neg_cnt = NEG_DIV5;
        end
        else
        begin
            last_cnt = LAST_DIV3;
            high_cnt = HIGH_DIV3;
            neg_cnt = NEG_DIV3;
        end
    end

    // ==========================================================
    // rising-edge group
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        pos_d = pos_q;
        ratio_d = ratio_q;
        halt_d = halt_q;
        // R9 freeze on loss guard
        if (!pins_s.loss)
        begin
            case (state_q)
                ST_OFF:
                begin
                    // R10 hold low, count parked
                    pos_d = 1'b0;
                    cnt_d = CNT_RESET;
                    halt_d = FLAG_RESET;
                    // R11 ratio follows pin only while off
                    ratio_d = pins_s.ratio5;
                    if (pins_s.enable)
                    begin
                        state_d = ST_ARM;
                    end
                end
                ST_ARM:
                begin
                    if (!pins_s.enable)
                    begin
                        state_d = ST_OFF;
                    end
                    // R3 wait for falling edge
                    else if (go_q)
                    begin
                        state_d = ST_RUN;
                        cnt_d = CNT_RESET;
                        pos_d = 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (cnt_q == last_cnt)
                    begin
                        // R4 R5 stop only at period end
                        if (!pins_s.enable || halt_q)
                        begin
                            state_d = ST_OFF;
                            cnt_d = CNT_RESET;
                            pos_d = 1'b0;
                            halt_d = FLAG_RESET;
                        end
                        else
                        begin
                            cnt_d = CNT_RESET;
                            pos_d = 1'b1;
                        end
                    end
                    else
                    begin
                        cnt_d = cnt_q + 3'h1;
                        pos_d = (cnt_q + 3'h1) < high_cnt;
                        // R4 low seen mid period
                        // a low that is gone again by period end still stops the run
                        if (!pins_s.enable)
                        begin
                            halt_d = 1'h1;
                        end
                    end
                end
                default:
                begin
                    state_d = ST_OFF;
                end
            endcase
        end
        running_d = (state_d == ST_RUN);
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_OFF;
            cnt_q <= CNT_RESET;
            pos_q <= FLAG_RESET;
            ratio_q <= PINS_RESET.ratio5;
            halt_q <= FLAG_RESET;
            running_q <= FLAG_RESET;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            ratio_q <= ratio_d;
            halt_q <= halt_d;
            running_q <= running_d;
        end
    end

    // ==========================================================
    // falling-edge group
    always_comb
    begin
        go_d = go_q;
        neg_d = neg_q;
        if (!pins_s.loss)
        begin
            // R3 falling edge after the arming rising edge
            go_d = (state_q == ST_ARM);
            // R6 R7 R8 half-cycle stretch sets the fall
            neg_d = (state_q == ST_RUN) && (cnt_q == neg_cnt);
        end
    end

    always_ff @(negedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            go_q <= FLAG_RESET;
            neg_q <= FLAG_RESET;
        end
        else
        begin
            go_q <= go_d;
            neg_q <= neg_d;
        end
    end

    // ==========================================================
    // outputs
    // overlap of the two halves keeps the OR free of gaps
    // R6 both edge groups combine
    assign div_out = pos_q | neg_q;
    // R10 complement high while disabled
    assign div_n_out = ~(pos_q | neg_q);
    // registered so the status pin cannot glitch on a state decode
    assign running_out = running_q;

endmodule : odc_divider

// ==== dv/odc_divider_sva.sv ====
// assertions on the divider pins
`timescale 1ns/1ps
module odc_divider_sva
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic ratio5_in,
    input wire logic loss_guard_in,
    input wire logic div_out,
    input wire logic div_n_out,
    input wire logic running_out
);
    // ==========
    // pin checks
    // loss aborts width checks, since a freeze may land mid pulse
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in || loss_guard_in);
    compl_pair_a: assert property (div_n_out == !div_out) else $error("pair");
    off_low_a: assert property (!running_out |-> !div_out) else $error("off high");
    high_three_a: assert property (@(negedge clock_in) disable iff (rst_in || loss_guard_in)
        !ratio5_in && $rose(div_out) |=> div_out ##1 !div_out) else $error("high3");
    high_five_a: assert property (@(negedge clock_in) disable iff (rst_in || loss_guard_in)
        ratio5_in && $rose(div_out) |=> div_out[*2] ##1 !div_out) else $error("high5");
    low_three_a: assert property (!ratio5_in && $fell(div_out) |=> !div_out) else $error("l3");
    low_five_a: assert property (ratio5_in && $fell(div_out) |=> !div_out[*2]) else $error("l5");
    start_delay_a: assert property (!running_out && $rose(enable_in)
        |=> !running_out ##[2:4] running_out) else $error("start");
    stop_delay_a: assert property (running_out && $fell(enable_in)
        |-> ##[1:9] !running_out) else $error("stop");
    freeze_hold_a: assert property (disable iff (rst_in)
        loss_guard_in && $past(loss_guard_in, 4) |-> $stable(div_out)) else $error("freeze");
endmodule : odc_divider_sva

// ==== dv/odc_pin_model.sv ====
// enable pin with its pull-up
`timescale 1ns/1ps
module odc_pin_model
(
    input wire logic drive_in,
    input wire logic level_in,
    output logic pin_out
);
    assign pin_out = drive_in ? level_in : 1'h1;
endmodule : odc_pin_model

// ==== dv/test_odd_ratio_clock_divider.sv ====
// bench for the odd ratio clock divider
`timescale 1ns/1ps
module test_odd_ratio_clock_divider;
    typedef struct {logic r5; int hi; int per;} odc_row_type;
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    logic drive = 1'h1;
    logic level = 1'h0;
    logic enable_in;
    logic ratio5_in = 1'h0;
    logic loss_guard_in = 1'h0;
    logic div_out;
    logic div_n_out;
    logic running_out;
    logic held;
    logic low_seen = 1'h0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int hi;
    int per;
    realtime t_rise;
    odc_row_type rows [2] = '{'{1'h0, 30, 60}, '{1'h1, 50, 100}};
    // ==========
    // harness
    initial forever #10 clock_in = ~clock_in;
    odc_pin_model pin (.drive_in(drive), .level_in(level), .pin_out(enable_in));
    odc_divider dut (.clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
        .ratio5_in(ratio5_in), .loss_guard_in(loss_guard_in), .div_out(div_out),
        .div_n_out(div_n_out), .running_out(running_out));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic measure;
        @(posedge div_out);
        t_rise = $realtime;
        @(negedge div_out);
        hi = int'($realtime - t_rise);
        @(posedge div_out);
        per = int'($realtime - t_rise);
        t_rise = $realtime;
    endtask : measure
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // hang guard, well above the roughly 120 cycles used
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        repeat (12) @(negedge clock_in);
        check("rst div", 8'h00, 8'(div_out));
        check("rst div_n", 8'h01, 8'(div_n_out));
        rst_in = 1'h0;
        foreach (rows[i])
        begin
            repeat (12) @(negedge clock_in);
            check("off run", 8'h00, 8'(running_out));
            check("off div_n", 8'h01, 8'(div_n_out));
            ratio5_in = rows[i].r5;
            repeat (3) @(negedge clock_in);
            level = 1'h1;
            measure();
            check("high", 8'(rows[i].hi), 8'(hi));
            check("period", 8'(rows[i].per), 8'(per));
            @(negedge clock_in);
            level = 1'h0;
            @(negedge div_out);
            check("last high", 8'(rows[i].hi), 8'(int'($realtime - t_rise)));
        end
        repeat (12) @(negedge clock_in);
        drive = 1'h0;
        repeat (8) @(negedge clock_in);
        check("open pin", 8'h01, 8'(running_out));
        @(negedge div_out);
        @(negedge clock_in);
        loss_guard_in = 1'h1;
        repeat (4) @(negedge clock_in);
        held = div_out;
        repeat (10) @(negedge clock_in);
        check("frozen", 8'(held), 8'(div_out));
        loss_guard_in = 1'h0;
        repeat (10) @(negedge clock_in);
        // one-cycle low on the pin must still end the run
        drive = 1'h1;
        @(negedge clock_in);
        drive = 1'h0;
        repeat (10)
        begin
            @(negedge clock_in);
            if (running_out === 1'h0)
                low_seen = 1'h1;
        end
        check("short low", 8'h01, 8'(low_seen));
        rst_in = 1'h1;
        #1;
        check("mid rst", 8'h00, 8'(running_out));
        conclude();
    end
endmodule : test_odd_ratio_clock_divider
bind odc_divider odc_divider_sva chk (.clock_in(clock_in), .rst_in(rst_in),
    .enable_in(enable_in), .ratio5_in(ratio5_in), .loss_guard_in(loss_guard_in),
    .div_out(div_out), .div_n_out(div_n_out), .running_out(running_out));
